// ### hw/cpr_regs.sv
// control registers and pcm slot logic of the voice codec path
// assumes control port pins asynchronous to clk; pcm pins timed by bclk
`default_nettype none
// Summary of operation
// - each register is reached by a command byte then a data byte
// - writing the loop bit as one enters digital loopback
// - in loopback the received slot byte is sent back in transmit slot
// - loopback stops decoding and encoding and mutes both amplifiers
// - mode bit 7 clear gives delayed timing; set picks normal or reverse
// - latch pin drives the inverse of its control bit
// - receive inject feeds the written byte to decoding, ignoring pcm input
// - receive data register reads the received slot byte, or the written byte when receive inject is set
// - transmit inject drives the written byte instead of the encoder
// - injects and slot choice act only in companded mode; the receive data register reads back in any mode
// - pcm words travel most significant bit first both ways
// - enable bit gates slots; when clear no decode and output floats
// - slot bit chooses first or second b channel, first by default
// - two-bit field chooses one of three microphones or transmit mute
// - sidetone bit switches feedback, forced off when transmit path off
// - output bits choose earpiece, extra output or mute; never both ones
// - tone route bit steers the tone generator to extra or earpiece amp
// - filter bit picks one of two receive high pass corners
// - voice route bit steers received speech to extra or earpiece amp
// - transmit gain nibble, 1.5 dB steps up to 22.5 dB
// - sidetone nibble, 1 dB attenuation steps from -12.5 dB
// - earpiece nibble, 2 dB steps from 0 dB down to -30 dB
module cpr_regs
  import cpr_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           reset,
  input  wire logic           ctl_sel_n,
  input  wire logic           ctl_clk,
  input  wire logic           ctl_din,
  output logic                ctl_dout,
  output logic                ctl_dout_oe,
  input  wire logic           companded,
  output logic                latch_pin,
  output cpr_pkg::cpr_afe_t   afe,
  input  wire logic           pcm_bclk,
  input  wire logic           pcm_fs,
  input  wire logic           pcm_in_pin,
  output logic                pcm_out_pin,
  output logic                pcm_out_oe,
  input  wire logic [7:0]     enc_byte,
  output logic [7:0]          dec_byte,
  output logic                dec_valid
);
  import cpr_pkg::*;

  // ********************************************
  // control port pin filtering
  // ********************************************
  logic [2:0] sel_sy, clk_sy, din_sy;
  logic       sel_f, cclk_f, din_f;
  logic       next_cclk;

  // three stages; a level counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (reset) begin
      sel_sy <= 3'h7;
      clk_sy <= 3'h0;
      din_sy <= 3'h0;
    end else begin
      sel_sy <= {sel_sy[1:0], ctl_sel_n};
      clk_sy <= {clk_sy[1:0], ctl_clk};
      din_sy <= {din_sy[1:0], ctl_din};
    end
  end

  assign next_cclk = (clk_sy[1] == clk_sy[2]) ? clk_sy[2] : cclk_f;

  always_ff @(posedge clk) begin
    if (reset) begin
      sel_f  <= 1'b1;
      cclk_f <= 1'b0;
      din_f  <= 1'b0;
    end else begin
      if (sel_sy[1] == sel_sy[2]) sel_f <= sel_sy[2];
      if (din_sy[1] == din_sy[2]) din_f <= din_sy[2];
      cclk_f <= next_cclk;
    end
  end

  logic ctl_rise, ctl_fall;
  assign ctl_rise = !sel_f && !cclk_f && next_cclk;
  assign ctl_fall = !sel_f && cclk_f && !next_cclk;

  // ********************************************
  // two-byte instruction engine
  // ********************************************
  logic [3:0] bit_cnt;
  logic [7:0] in_sh;
  logic [7:0] cmd;
  logic [7:0] out_sh;
  logic       wr_stb;
  logic [3:0] wr_reg;
  logic [7:0] wr_data;
  logic [7:0] rd_val;

  // bits taken on rising control clock, msb first
  always_ff @(posedge clk) begin
    if (reset || sel_f) begin
      bit_cnt <= 4'h0;
      in_sh   <= 8'h00;
      cmd     <= 8'h00;
      wr_stb  <= 1'b0;
      wr_reg  <= 4'h0;
      wr_data <= 8'h00;
    end else begin
      wr_stb <= 1'b0;
      if (ctl_rise) begin
        in_sh   <= {in_sh[6:0], din_f};
        bit_cnt <= bit_cnt + 4'h1;
        if (bit_cnt == {1'b0, BYTE_LAST_BIT}) begin
          cmd <= {in_sh[6:0], din_f};
        end
        if (bit_cnt == INSTR_LAST_BIT && !cmd[CMD_READ_BIT]) begin
          wr_stb  <= 1'b1;
          wr_reg  <= cmd[CMD_REG_MSB:0];
          wr_data <= {in_sh[6:0], din_f};
        end
      end
    end
  end

  // read data shifts out on falling edges during the second byte
  always_ff @(posedge clk) begin
    if (reset || sel_f) begin
      out_sh      <= 8'h00;
      ctl_dout    <= 1'b0;
      ctl_dout_oe <= 1'b0;
    end else if (ctl_fall) begin
      if (bit_cnt == 4'h8 && cmd[CMD_READ_BIT]) begin
        ctl_dout    <= rd_val[7];
        out_sh      <= {rd_val[6:0], 1'b0};
        ctl_dout_oe <= 1'b1;
      end else if (bit_cnt == 4'h0 || bit_cnt > 4'h8) begin
        ctl_dout    <= out_sh[7];
        out_sh      <= {out_sh[6:0], 1'b0};
        ctl_dout_oe <= ctl_dout_oe && bit_cnt != 4'h0;
      end
    end
  end

  // ********************************************
  // register file
  // ********************************************
  logic [7:0] pcm_if, route, tx_gain, rx_gain;
  logic [7:0] rx_wr_byte, tx_wr_byte, rx_cap_byte;

  always_ff @(posedge clk) begin
    if (reset) begin
      pcm_if     <= RST_PCM_IF;
      route      <= RST_ROUTE;
      tx_gain    <= RST_TX_GAIN;
      rx_gain    <= RST_RX_GAIN;
      rx_wr_byte <= RST_BYTE;
      tx_wr_byte <= RST_BYTE;
    end else if (wr_stb) begin
      case (wr_reg)
        REG_PCM_IF:  pcm_if     <= wr_data;
        REG_RX_BYTE: rx_wr_byte <= wr_data;
        REG_TX_BYTE: tx_wr_byte <= wr_data;
        REG_ROUTE:   route      <= wr_data;
        REG_TX_GAIN: tx_gain    <= wr_data;
        REG_RX_GAIN: rx_gain    <= wr_data;
        default:     ;
      endcase
    end
  end

  // read mux; transmit byte is write only, unmapped reads give zero
  always_comb begin
    rd_val = 8'h00;
    case (cmd[CMD_REG_MSB:0])
      REG_PCM_IF:  rd_val = pcm_if;
      REG_RX_BYTE: rd_val = pcm_if[PIF_RX_INJ] ? rx_wr_byte
                                               : rx_cap_byte;
      REG_ROUTE:   rd_val = route;
      REG_TX_GAIN: rd_val = tx_gain;
      REG_RX_GAIN: rd_val = rx_gain;
      default:     rd_val = 8'h00;
    endcase
  end

  // ********************************************
  // analog front end decode
  // ********************************************
  logic [1:0] mic;
  logic       out_a, out_b;
  assign mic   = {route[RTE_MIC_B1], route[RTE_MIC_B0]};
  assign out_a = route[RTE_OUT_A];
  assign out_b = route[RTE_OUT_B];

  // step counts pass straight through; code zero is the first step
  always_comb begin
    afe.mic_pick        = mic;
    afe.sidetone_on     = route[RTE_SIDETONE]
                          && mic != MIC_MUTE;
    afe.ear_out_en      = out_a && !out_b;
    afe.extra_out_en    = out_b && !out_a;
    afe.tone_route      = route[RTE_TONE];
    afe.rx_hpf_corner   = route[RTE_HPF];
    afe.rx_voice_route  = route[RTE_VOICE];
    afe.tx_gain_step    = tx_gain[GAIN_HI_LSB +: 4];
    afe.sidetone_step   = tx_gain[GAIN_LO_LSB +: 4];
    afe.ear_gain_step   = rx_gain[GAIN_HI_LSB +: 4];
    afe.extra_gain_step = rx_gain[GAIN_LO_LSB +: 4];
    afe.tx_amp_mute     = pcm_if[PIF_LOOP] || mic == MIC_MUTE;
    afe.rx_amp_mute     = pcm_if[PIF_LOOP];
  end

  assign latch_pin = !pcm_if[PIF_LATCH];

  // ********************************************
  // crossing into the bit clock domain
  // ********************************************
  cpr_pcm_cfg_t cfg_src, cfg_link;
  logic         cfg_req, cfg_busy;
  logic [1:0]   ack_sy;
  logic [2:0]   req_sy;
  logic         cfg_ack;
  logic [1:0]   lrst_sy;
  logic         comp_q;

  always_ff @(posedge clk) begin
    if (reset) comp_q <= 1'b0;
    else       comp_q <= companded;
  end

  // injects and slot choice are masked outside companded coding
  assign cfg_busy = cfg_req != ack_sy[1];
  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_src <= '0;
      cfg_req <= 1'b0;
      ack_sy  <= 2'h0;
    end else begin
      ack_sy <= {ack_sy[0], cfg_ack};
      if (!cfg_busy) begin
        cfg_src.mode_hi <= pcm_if[PIF_MODE_HI];
        cfg_src.mode_lo <= pcm_if[PIF_MODE_LO];
        cfg_src.rx_inj  <= pcm_if[PIF_RX_INJ] && comp_q;
        cfg_src.tx_inj  <= pcm_if[PIF_TX_INJ] && comp_q;
        cfg_src.enable  <= pcm_if[PIF_ENABLE];
        cfg_src.slot    <= pcm_if[PIF_SLOT] && comp_q;
        cfg_src.loop    <= pcm_if[PIF_LOOP];
        cfg_src.rx_byte <= rx_wr_byte;
        cfg_src.tx_byte <= tx_wr_byte;
        cfg_req         <= !cfg_req;
      end
    end
  end

  // link side reset and request toggle synchronisers
  always_ff @(posedge pcm_bclk) begin
    lrst_sy <= {lrst_sy[0], reset};
  end

  logic lrst;
  assign lrst = lrst_sy[1];

  always_ff @(posedge pcm_bclk) begin
    if (lrst) begin
      req_sy   <= 3'h0;
      cfg_ack  <= 1'b0;
      cfg_link <= '0;
    end else begin
      req_sy <= {req_sy[1:0], cfg_req};
      if (req_sy[1] != req_sy[2]) begin
        cfg_link <= cfg_src;
        cfg_ack  <= req_sy[1];
      end
    end
  end

  // ********************************************
  // pcm frame timing and slots
  // ********************************************
  cpr_timing_t timing;
  logic        fs_q, fs_qq, start;
  logic [3:0]  pos;
  logic        active;
  logic        in_slot;
  logic [7:0]  rx_sh, tx_word, loop_byte, rx_link_byte;
  logic        rx_tog;

  // mode bit 7 clear means delayed, its companion picks normal or reverse
  always_comb begin
    if (!cfg_link.mode_hi)     timing = CPR_TIMING_DELAYED;
    else if (!cfg_link.mode_lo) timing = CPR_TIMING_NORMAL;
    else                        timing = CPR_TIMING_REVERSE;
  end

  always_comb begin
    case (timing)
      CPR_TIMING_NORMAL:  start = pcm_fs && !fs_q;
      CPR_TIMING_DELAYED: start = fs_q && !fs_qq;
      CPR_TIMING_REVERSE: start = !pcm_fs && fs_q;
      default:            start = 1'b0;
    endcase
  end

  assign in_slot = active && pos[3] == cfg_link.slot;

  // bit position in the frame, sixteen bits covering both b channels
  always_ff @(posedge pcm_bclk) begin
    if (lrst) begin
      fs_q   <= 1'b0;
      fs_qq  <= 1'b0;
      pos    <= 4'h0;
      active <= 1'b0;
    end else begin
      fs_q  <= pcm_fs;
      fs_qq <= fs_q;
      if (start) begin
        pos    <= 4'h0;
        active <= 1'b1;
      end else if (active) begin
        pos    <= pos + 4'h1;
        active <= pos != FRAME_LAST_POS;
      end
    end
  end

  // transmit word source chosen once per frame
  always_ff @(posedge pcm_bclk) begin
    if (lrst) begin
      tx_word <= 8'h00;
    end else if (start) begin
      if (cfg_link.loop)        tx_word <= loop_byte;
      else if (cfg_link.tx_inj) tx_word <= cfg_link.tx_byte;
      else                      tx_word <= enc_byte;
    end
  end

  // output driven msb first; floats unless enabled and in slot
  logic [3:0] next_pos;
  logic       next_in_slot;
  logic [7:0] next_word;
  assign next_pos     = start ? 4'h0 : pos + 4'h1;
  assign next_in_slot = (start || (active && pos != FRAME_LAST_POS))
                        && next_pos[3] == cfg_link.slot;
  assign next_word    = start ? (cfg_link.loop ? loop_byte
                        : cfg_link.tx_inj ? cfg_link.tx_byte : enc_byte)
                        : tx_word;

  always_ff @(posedge pcm_bclk) begin
    if (lrst) begin
      pcm_out_pin <= 1'b0;
      pcm_out_oe  <= 1'b0;
    end else begin
      pcm_out_pin <= next_word[~next_pos[2:0]];
      pcm_out_oe  <= next_in_slot && cfg_link.enable;
    end
  end

  // receive shift, msb first; byte complete on the slot's last bit
  always_ff @(posedge pcm_bclk) begin
    if (lrst) begin
      rx_sh        <= 8'h00;
      loop_byte    <= 8'h00;
      rx_link_byte <= 8'h00;
      rx_tog       <= 1'b0;
      dec_byte     <= 8'h00;
      dec_valid    <= 1'b0;
    end else begin
      dec_valid <= 1'b0;
      if (in_slot) begin
        rx_sh <= {rx_sh[6:0], pcm_in_pin};
        if (pos[2:0] == BYTE_LAST_BIT) begin
          loop_byte    <= {rx_sh[6:0], pcm_in_pin};
          rx_link_byte <= {rx_sh[6:0], pcm_in_pin};
          rx_tog       <= !rx_tog;
          dec_byte     <= cfg_link.rx_inj ? cfg_link.rx_byte
                          : {rx_sh[6:0], pcm_in_pin};
          dec_valid    <= cfg_link.enable && !cfg_link.loop;
        end
      end
    end
  end

  // ********************************************
  // captured byte back to the register side
  // ********************************************
  logic [2:0] rxt_sy;
  always_ff @(posedge clk) begin
    if (reset) begin
      rxt_sy      <= 3'h0;
      rx_cap_byte <= RST_BYTE;
    end else begin
      rxt_sy <= {rxt_sy[1:0], rx_tog};
      if (rxt_sy[1] != rxt_sy[2]) rx_cap_byte <= rx_link_byte;
    end
  end

  // ********************************************
  // checks
  // ********************************************
  latch_write_a: assert property (@(posedge clk) disable iff (reset)
    wr_stb && wr_reg == REG_PCM_IF |=> latch_pin == !$past(wr_data[PIF_LATCH]))
    else $error("latch pin not inverse of written bit");

  loop_write_a: assert property (@(posedge clk) disable iff (reset)
    wr_stb && wr_reg == REG_PCM_IF && wr_data[PIF_LOOP]
      |=> afe.rx_amp_mute && afe.tx_amp_mute)
    else $error("loop write did not mute amplifiers");

  side_mute_a: assert property (@(posedge clk) disable iff (reset)
    mic == MIC_MUTE |-> !afe.sidetone_on)
    else $error("sidetone on with transmit muted");

  out_excl_a: assert property (@(posedge clk) disable iff (reset)
    !(afe.ear_out_en && afe.extra_out_en))
    else $error("both outputs enabled");

  gain_write_a: assert property (@(posedge clk) disable iff (reset)
    wr_stb && wr_reg == REG_TX_GAIN
      |=> afe.tx_gain_step == $past(wr_data[7:4])
          && afe.sidetone_step == $past(wr_data[3:0]))
    else $error("gain register not applied");

  read_first_a: assert property (@(posedge clk) disable iff (reset)
    ctl_fall && bit_cnt == 4'h8 && cmd[CMD_READ_BIT]
      |=> ctl_dout == $past(rd_val[7]) && ctl_dout_oe)
    else $error("read data msb not driven");

  comp_mask_a: assert property (@(posedge clk) disable iff (reset)
    !cfg_busy && !comp_q |=> !cfg_src.rx_inj && !cfg_src.tx_inj)
    else $error("inject passed in linear coding");

  link_float_a: assert property (@(posedge pcm_bclk) disable iff (lrst)
    !cfg_link.enable |=> !pcm_out_oe)
    else $error("pcm output driven while disabled");

  loop_decode_a: assert property (@(posedge pcm_bclk) disable iff (lrst)
    cfg_link.loop |=> !dec_valid)
    else $error("decode during loopback");

  slot_bits_a: assert property (@(posedge pcm_bclk) disable iff (lrst)
    start && cfg_link.enable && !cfg_link.slot
      ##1 (cfg_link.enable && !cfg_link.slot)[*8]
      |-> $past(pcm_out_oe, 1))
    else $error("first slot not driven for eight bits");

  cover_write_c:  cover property (@(posedge clk) disable iff (reset)
    wr_stb && wr_reg == REG_PCM_IF);
  cover_read_c:   cover property (@(posedge clk) disable iff (reset)
    ctl_fall && bit_cnt == 4'h8 && cmd[CMD_READ_BIT]);
  cover_loop_c:   cover property (@(posedge pcm_bclk) disable iff (lrst)
    cfg_link.loop && cfg_link.enable && pcm_out_oe);
  cover_inject_c: cover property (@(posedge pcm_bclk) disable iff (lrst)
    cfg_link.rx_inj && in_slot && pos[2:0] == BYTE_LAST_BIT);
endmodule
`default_nettype wire

// ### pkg/cpr_pkg.sv
// package of the codec pcm path control registers: map, fields, types
// assumes one control port and one pcm link clocked by the bit clock
`default_nettype none
package cpr_pkg;
  // register numbers carried in the first instruction byte
  localparam logic [3:0] REG_PCM_IF   = 4'h1; // pcm_interface_config
  localparam logic [3:0] REG_RX_BYTE  = 4'h2; // receive_byte_access
  localparam logic [3:0] REG_TX_BYTE  = 4'h3; // transmit_byte_inject
  localparam logic [3:0] REG_ROUTE    = 4'h4; // audio_routing_select
  localparam logic [3:0] REG_TX_GAIN  = 4'h5; // tx_and_feedback_gain
  localparam logic [3:0] REG_RX_GAIN  = 4'h6; // receive_output_gain
  // first byte: bit 7 selects read, bits 3..0 the register
  localparam int CMD_READ_BIT = 7;
  localparam int CMD_REG_MSB  = 3;
  // pcm_interface_config fields
  localparam int PIF_MODE_HI  = 7;
  localparam int PIF_MODE_LO  = 6;
  localparam int PIF_LATCH    = 5;
  localparam int PIF_RX_INJ   = 4;
  localparam int PIF_TX_INJ   = 3;
  localparam int PIF_ENABLE   = 2;
  localparam int PIF_SLOT     = 1;
  localparam int PIF_LOOP     = 0;
  // audio_routing_select fields
  localparam int RTE_MIC_B1   = 7;
  localparam int RTE_MIC_B0   = 6;
  localparam int RTE_SIDETONE = 5;
  localparam int RTE_OUT_A    = 4;
  localparam int RTE_OUT_B    = 3;
  localparam int RTE_TONE     = 2;
  localparam int RTE_HPF      = 1;
  localparam int RTE_VOICE    = 0;
  // gain fields: upper nibble and lower nibble
  localparam int GAIN_HI_LSB  = 4;
  localparam int GAIN_LO_LSB  = 0;
  // transmit input code meaning muted transmit path
  localparam logic [1:0] MIC_MUTE = 2'h0;
  // reset values
  localparam logic [7:0] RST_PCM_IF  = 8'h00;
  localparam logic [7:0] RST_ROUTE   = 8'h00;
  localparam logic [7:0] RST_TX_GAIN = 8'h00;
  localparam logic [7:0] RST_RX_GAIN = 8'h00;
  localparam logic [7:0] RST_BYTE    = 8'h00;
  // instruction and frame geometry
  localparam logic [3:0] INSTR_LAST_BIT = 4'hf;
  localparam logic [2:0] BYTE_LAST_BIT  = 3'h7;
  localparam logic [3:0] FRAME_LAST_POS = 4'hf;

  typedef enum logic [1:0] {
    CPR_TIMING_DELAYED,
    CPR_TIMING_NORMAL,
    CPR_TIMING_REVERSE
  } cpr_timing_t;

  // settings handed from the register side to the pcm side
  typedef struct packed {
    logic       mode_hi;
    logic       mode_lo;
    logic       rx_inj;
    logic       tx_inj;
    logic       enable;
    logic       slot;
    logic       loop;
    logic [7:0] rx_byte;
    logic [7:0] tx_byte;
  } cpr_pcm_cfg_t;

  // analog front end settings decoded from the registers
  typedef struct packed {
    logic [1:0] mic_pick;
    logic       sidetone_on;
    logic       ear_out_en;
    logic       extra_out_en;
    logic       tone_route;
    logic       rx_hpf_corner;
    logic       rx_voice_route;
    logic [3:0] tx_gain_step;
    logic [3:0] sidetone_step;
    logic [3:0] ear_gain_step;
    logic [3:0] extra_gain_step;
    logic       tx_amp_mute;
    logic       rx_amp_mute;
  } cpr_afe_t;
endpackage
`default_nettype wire

// ### bench/cpr_pcm_partner.sv
// pcm link partner: frame master that drives sync and data on the link
// assumes the bench runs pcm_bclk and sets the timing mode and send word
`default_nettype none
module cpr_pcm_partner (
  input  wire logic        pcm_bclk,
  input  wire logic [1:0]  mode,
  input  wire logic [15:0] send,
  input  wire logic        pcm_out_pin,
  input  wire logic        pcm_out_oe,
  output logic             pcm_fs,
  output logic             pcm_in_pin,
  output logic [15:0]      got,
  output logic [15:0]      got_oe,
  output int               frames
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // frame walk, 32 bit clocks a frame
  // ****************************************
  int          k = 0;
  logic [15:0] sh;
  logic [15:0] cap;
  logic [15:0] cap_oe;
  initial begin
    pcm_fs = 1'b0;
    pcm_in_pin = 1'b0;
  end
  // change on the fall so every level is settled at the sampling rise
  always @(negedge pcm_bclk) begin
    k <= (k == 31) ? 0 : k + 1;
    // mode 0 delayed, 1 normal, 2 reverse; start edge is always the same
    pcm_fs <= (k == 0) ? (mode != 2'h1) : (k == 1) ? (mode != 2'h2) : 1'b0;
    if (k == 0)
      sh <= send;
    if (k >= 2 && k <= 17) begin
      pcm_in_pin <= sh[17 - k];
      cap <= {cap[14:0], pcm_out_pin};
      cap_oe <= {cap_oe[14:0], pcm_out_oe};
    end else
      pcm_in_pin <= ~pcm_in_pin;  // no stale data outside the slots
    if (k == 18) begin
      got <= cap;
      got_oe <= cap_oe;
      frames <= frames + 1;
    end
  end
endmodule
`default_nettype wire

// ### bench/cpr_regs_tb_top.sv
// bench for the pcm path control registers: control port and pcm frames
// assumes cpr_pkg and cpr_pcm_partner are compiled before it
`default_nettype none
module cpr_regs_tb_top
  import cpr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // signals, model and clocks
  // ****************************************
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        ctl_sel_n = 1'b1;
  logic        ctl_clk = 1'b0;
  logic        ctl_din = 1'b0;
  logic        companded = 1'b0;
  logic        pcm_bclk = 1'b0;
  logic [7:0]  enc_byte = 8'h00;
  logic [1:0]  mode = 2'h0;
  logic [15:0] send = 16'h0000;
  logic        ctl_dout, ctl_dout_oe, latch_pin, pcm_fs, pcm_in_pin;
  logic        pcm_out_pin, pcm_out_oe, dec_valid;
  logic [7:0]  dec_byte, v, r, t;
  logic [15:0] got, got_oe;
  cpr_afe_t    afe;
  int          frames, dv, cycles, errors, check_count;
  int          mdl [8];
  always #2.5 clk = ~clk;
  // odd start offset keeps the link edges apart from the system edges
  initial begin
    #13.3;
    forever #40 pcm_bclk = ~pcm_bclk;
  end
  always @(posedge pcm_bclk) if (dec_valid === 1'b1) dv++;
  cpr_regs DUT (
    .clk(clk), .reset(reset), .ctl_sel_n(ctl_sel_n), .ctl_clk(ctl_clk),
    .ctl_din(ctl_din), .ctl_dout(ctl_dout), .ctl_dout_oe(ctl_dout_oe),
    .companded(companded), .latch_pin(latch_pin), .afe(afe),
    .pcm_bclk(pcm_bclk), .pcm_fs(pcm_fs), .pcm_in_pin(pcm_in_pin),
    .pcm_out_pin(pcm_out_pin), .pcm_out_oe(pcm_out_oe),
    .enc_byte(enc_byte), .dec_byte(dec_byte), .dec_valid(dec_valid));
  cpr_pcm_partner far (
    .pcm_bclk(pcm_bclk), .mode(mode), .send(send),
    .pcm_out_pin(pcm_out_pin), .pcm_out_oe(pcm_out_oe), .pcm_fs(pcm_fs),
    .pcm_in_pin(pcm_in_pin), .got(got), .got_oe(got_oe), .frames(frames));
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // one instruction; each clock level held 8 cycles, well over the minimum
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] dat,
                      output logic [7:0] rd);
    logic [15:0] w;
    w = {cmd, dat};
    rd = 8'h00;
    @(negedge clk);
    ctl_sel_n = 1'b0;
    for (int i = 0; i < 16; i++) begin
      ctl_clk = 1'b0;
      ctl_din = w[15 - i];
      repeat (8) @(negedge clk);
      ctl_clk = 1'b1;
      if (i >= 8 && cmd[7]) begin
        rd = {rd[6:0], ctl_dout};
        chk("ctl_dout_oe", 1, ctl_dout_oe);
      end
      repeat (8) @(negedge clk);
    end
    ctl_clk = 1'b0;
    ctl_sel_n = 1'b1;
    if (!cmd[7] && cmd[3:0] inside {1, 2, 4, 5, 6})
      mdl[cmd[3:0]] = dat;
    repeat (8) @(negedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] x;
    xfer({4'h0, a}, d, x);
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] x;
    xfer({4'h8, a}, 8'h00, x);
    chk("read", e, x);
  endtask
  // wait k frame ends; dv counts decodes of the last frame only
  // window shifted two bit clocks: a second-slot decode lands after the end
  task automatic fw(input int k);
    int n;
    n = frames;
    wait (frames == n + k - 1);
    repeat (2) @(negedge pcm_bclk);
    dv = 0;
    wait (frames == n + k);
    repeat (2) @(negedge pcm_bclk);
    @(negedge clk);
  endtask
  task automatic pcm_run(input logic [7:0] p, input logic [15:0] s);
    wr(4'h1, p);
    send = s;
    fw(2);
  endtask
  task automatic afe_chk();
    cpr_afe_t e;
    e = '0;
    {e.mic_pick, e.sidetone_on} = mdl[4][7:5];
    if (e.mic_pick == MIC_MUTE)
      e.sidetone_on = 1'b0;
    {e.ear_out_en, e.extra_out_en} = mdl[4][4:3];
    {e.tone_route, e.rx_hpf_corner, e.rx_voice_route} = mdl[4][2:0];
    {e.tx_gain_step, e.sidetone_step} = mdl[5][7:0];
    {e.ear_gain_step, e.extra_gain_step} = mdl[6][7:0];
    chk("afe", e[25:2], afe[25:2]);
    chk("latch_pin", !mdl[1][5], latch_pin);
    if (mdl[1][0])
      chk("amp_mute", 2'h3, afe[1:0]);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // hang guard, well above the roughly 30k cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      errors++;
      $display("ERROR timeout expected finish seen hang");
      print_verdict();
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(32'hacb6));
    repeat (8) @(negedge clk);
    repeat (3) @(posedge pcm_bclk);
    @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    chk("latch_pin", 1, latch_pin);
    for (int a = 1; a < 8; a++) rdchk(a[3:0], 8'h00);
    $display("test reset done");
    for (int n = 0; n < 4; n++) begin
      for (int a = 1; a < 8; a++) begin
        v = 8'($urandom);
        if (a == 4 && v[4])
          v[3] = 1'b0;
        wr(a[3:0], v);
        if (a != 2)
          rdchk(a[3:0], (a inside {1, 4, 5, 6}) ? mdl[a][7:0] : 8'h00);
      end
      afe_chk();
    end
    $display("test registers done");
    companded = 1'b1;
    enc_byte = 8'($urandom);
    r = 8'($urandom);
    for (int s = 0; s < 2; s++) begin
      pcm_run(s ? 8'h06 : 8'h04, s ? {~r, r} : {r, ~r});
      chk("out_byte", enc_byte, s ? got[7:0] : got[15:8]);
      chk("out_oe", s ? 16'h00ff : 16'hff00, got_oe);
      chk("dec_byte", r, dec_byte);
      chk("dec_valid", 1, dv);
      rdchk(4'h2, r);
    end
    for (int m = 0; m < 3; m++) begin
      t = 8'($urandom);
      wr(4'h3, t);
      mode = m[1:0];
      pcm_run({m != 0, m == 2, 6'h0c}, {r, r});
      chk("inject_byte", t, got[15:8]);
      chk("inject_oe", 16'hff00, got_oe);
    end
    mode = 2'h1;
    pcm_run(8'h0c, {r, r});
    // delayed timing against a one-bit sync: slot starts one bit late
    chk("late_start_oe", 16'h7f80, got_oe);
    mode = 2'h0;
    $display("test slots and modes done");
    t = ~r;
    wr(4'h2, t);
    pcm_run(8'h14, {r, r});
    chk("dec_inject", t, dec_byte);
    rdchk(4'h2, t);
    pcm_run(8'h05, {r, 8'h00});
    send = {~r, 8'h00};
    fw(1);
    chk("loop_byte", r, got[15:8]);
    chk("loop_decode", 0, dv);
    afe_chk();
    pcm_run(8'h08, {r, r});
    chk("off_oe", 0, got_oe);
    chk("off_decode", 0, dv);
    companded = 1'b0;
    pcm_run(8'h0e, {r, r});
    chk("linear_byte", enc_byte, got[15:8]);
    chk("linear_oe", 16'hff00, got_oe);
    $display("test inject loop and disable done");
    print_verdict();
  end
endmodule
`default_nettype wire
